// ==== rtl/cs_pkg.sv ====
// Contract
// [RULE_01] four identical select units, each with a 16-bit base and option register
// [RULE_02] decode all masters; matching select goes low once address strobe falls
// [RULE_03] several enabled hits set conflict flag; bus error when conflict enable set
// [RULE_04] only one select asserted; line 0 highest, line 3 lowest priority
// [RULE_05] write to read-only region: no select, set protect flag, optional bus error
// [RULE_06] select registers and logic reset only by reset together with halt
// [RULE_07] on-chip RAM and register accesses never assert a select line
// [RULE_08] interrupt acknowledge cycles never produce an address match
// [RULE_09] base: space 15-13, address A23-A13 in 12-2, direction bit 1, enable bit 0
// [RULE_10] enable 0 disables, 1 enables; after reset only line 0 enabled
// [RULE_11] direction bit 0 reads only, 1 writes only; resets to 0
// [RULE_12] direction mask 0 ignores direction bit, 1 applies it; resets to 0
// [RULE_13] option mask bits 12-2 for A23-A13; 1 compares bit, 0 ignores it
// [RULE_14] reset clears base addresses and sets every mask bit to one
// [RULE_15] space field compared with function code; 111 reserved; resets to 110
// [RULE_16] compare-space bit 0 ignores space field, 1 requires match; resets to 1
// [RULE_17] option bits 15-13: 000..110 give 0..6 wait states, 111 external ack
// [RULE_18] with code 111 device leaves ack undriven; master waits for peripheral
// [RULE_19] wait states counted on internal clock, also for external masters
// [RULE_20] zero wait states: acknowledge given without waiting for counting
// [RULE_21] outside parties must not drive ack for internally acknowledged regions
// [RULE_22] software should set external-master wait bit when timing needs it
// [RULE_23] external-master wait bit adds one wait state to external master cycles
// [RULE_24] conflict while accessing system configuration register: no flag, no error
// [RULE_25] select and internal ack negate when address strobe negates
package cs_pkg;

	localparam int          NUM_LINES_DEF = 4;
	localparam int          ADDR_W        = 11;

	// register indices on the plain register port
	localparam logic [3:0]  REG_BR_BASE   = 4'h0;
	localparam logic [3:0]  REG_OR_BASE   = 4'h4;
	localparam logic [3:0]  REG_CTRL      = 4'h8;

	// base register fields
	localparam int          BR_SPACE_LSB  = 13;
	localparam int          BR_ADDR_LSB   = 2;
	localparam int          BR_DIR_BIT    = 1;
	localparam int          BR_EN_BIT     = 0;
	// option register fields
	localparam int          OR_ACK_LSB    = 13;
	localparam int          OR_MASK_LSB   = 2;
	localparam int          OR_DMASK_BIT  = 1;
	localparam int          OR_CSPACE_BIT = 0;
	// control/status register fields
	localparam int          CT_WPF_BIT    = 0;
	localparam int          CT_ADC_BIT    = 1;
	localparam int          CT_WPE_BIT    = 2;
	localparam int          CT_DECODE_CONFLICT_ENABLE_BIT   = 3;
	localparam int          CT_EXTERNAL_MASTER_WAIT_STATE_BIT   = 4;

	localparam logic [15:0] BR0_RST       = 16'hC001;
	localparam logic [15:0] BRN_RST       = 16'hC000;
	localparam logic [15:0] OR_RST        = 16'hDFFD;
	localparam logic [2:0]  ACK_EXTERNAL  = 3'h7;
	localparam logic [2:0]  FC_IACK       = 3'h7;
	localparam logic [2:0]  CNT_ZERO      = 3'h0;

	typedef struct packed {
		logic              strobe_n;
		logic              read;
		logic [2:0]        space;
		logic [ADDR_W-1:0] addr;
		logic              ext;
	} pin_t;

	typedef struct packed {
		logic external_master_wait_state;
		logic decode_conflict_enable;
		logic wpe;
		logic adc;
		logic wpf;
	} ctrl_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b10
	} st_t;

endpackage

// ==== rtl/chip_select_wait_state_unit.sv ====
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module chip_select_wait_state_unit
	import cs_pkg::*;
#(
	parameter int NUM_LINES = NUM_LINES_DEF
)
(
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	input  wire logic                 halt_in,
	input  wire logic [3:0]           reg_addr_in,
	input  wire logic [15:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic      [15:0]          reg_rdata_out,
	input  wire logic                 address_strobe_n_in,
	input  wire logic                 read_in,
	input  wire logic [2:0]           space_in,
	input  wire logic [ADDR_W-1:0]    addr_hi_in,
	input  wire logic                 ext_master_in,
	input  wire logic                 int_space_in,
	input  wire logic                 cfg_access_in,
	output logic      [NUM_LINES-1:0] select_line_n_out,
	output logic                      transfer_ack_n_out,
	output logic                      transfer_ack_oe_out,
	output logic                      bus_error_n_out,
	output logic                      periph_wait_out
);

	logic                 sys_rst;
	pin_t                 pin_in;
	pin_t                 sync1_r;
	pin_t                 sync2_r;
	logic                 as_act;
	logic                 iack;
	logic [15:0]          br_r [NUM_LINES];
	logic [15:0]          or_r [NUM_LINES];
	ctrl_t                ctrl_r;
	logic [NUM_LINES-1:0] hit;
	logic [NUM_LINES-1:0] dir_ok;
	logic [NUM_LINES-1:0] wprot;
	logic [NUM_LINES-1:0] win;
	logic                 win_ok;
	logic                 win_wp;
	logic [2:0]           win_code;
	logic                 conflict;
	logic                 decide;
	logic                 wp_evt;
	logic                 adc_evt;
	logic                 ack_go;
	logic [2:0]           cnt_init;
	st_t                  st_r;
	logic [2:0]           cnt_r;

	// select registers obey only the combined reset and halt
	assign sys_rst = rst_in & halt_in; // RULE_06

	function automatic logic [NUM_LINES-1:0] first_hit(input logic [NUM_LINES-1:0] v);
		logic [NUM_LINES-1:0] r;
		r = '0;
		for (int k = NUM_LINES - 1; k >= 0; k--)
		begin
			if (v[k])
			begin
				r = '0;
				r[k] = 1'b1;
			end
		end
		return r;
	endfunction

	assign pin_in = '{strobe_n: address_strobe_n_in, read: read_in, space: space_in,
		addr: addr_hi_in, ext: ext_master_in};

	// two-stage capture of the external bus pins
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst)
		begin
			sync1_r <= '{strobe_n: 1'b1, default: '0};
			sync2_r <= '{strobe_n: 1'b1, default: '0};
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	assign as_act = ~sync2_r.strobe_n;
	assign iack   = (sync2_r.space == FC_IACK); // RULE_08

	// per-line address, space and direction compare
	for (genvar i = 0; i < NUM_LINES; i++)
	begin : g_line
		logic [ADDR_W-1:0] msk;
		logic              sp_ok;
		assign msk = or_r[i][OR_MASK_LSB +: ADDR_W];
		assign sp_ok = ~or_r[i][OR_CSPACE_BIT] |
			(sync2_r.space == br_r[i][BR_SPACE_LSB +: 3]); // RULE_15 RULE_16
		assign hit[i] = br_r[i][BR_EN_BIT] & sp_ok &
			((sync2_r.addr & msk) == (br_r[i][BR_ADDR_LSB +: ADDR_W] & msk)); // RULE_10 RULE_13
		assign dir_ok[i] = ~or_r[i][OR_DMASK_BIT] |
			(br_r[i][BR_DIR_BIT] == ~sync2_r.read); // RULE_11 RULE_12
		assign wprot[i] = or_r[i][OR_DMASK_BIT] & ~br_r[i][BR_DIR_BIT] & ~sync2_r.read;
	end

	always_comb
	begin
		win      = first_hit(hit); // RULE_04
		win_ok   = |(win & dir_ok);
		win_wp   = |(win & wprot);
		win_code = '0;
		for (int k = 0; k < NUM_LINES; k++)
		begin
			if (win[k])
			begin
				win_code = or_r[k][OR_ACK_LSB +: 3];
			end
		end
	end

	assign conflict = ~$onehot0(hit);
	// internal space and interrupt acknowledge never decode
	assign decide   = (st_r == ST_IDLE) & as_act & ~int_space_in & ~iack; // RULE_02 RULE_07 RULE_08
	assign wp_evt   = decide & win_wp; // RULE_05
	assign adc_evt  = decide & conflict & ~cfg_access_in; // RULE_03 RULE_24
	assign ack_go   = decide & win_ok & (win_code != ACK_EXTERNAL); // RULE_17 RULE_18
	assign cnt_init = win_code + {2'b00, ctrl_r.external_master_wait_state & sync2_r.ext}; // RULE_23

	// register file writes
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst)
		begin
			for (int k = 0; k < NUM_LINES; k++)
			begin
				br_r[k] <= (k == 0) ? BR0_RST : BRN_RST; // RULE_10 RULE_14 RULE_15
				or_r[k] <= OR_RST; // RULE_14 RULE_16 RULE_12
			end
		end
		else if (reg_wr_in)
		begin
			for (int k = 0; k < NUM_LINES; k++)
			begin
				if (reg_addr_in == REG_BR_BASE + 4'(k))
				begin
					br_r[k] <= reg_wdata_in; // RULE_01 RULE_09
				end
				if (reg_addr_in == REG_OR_BASE + 4'(k))
				begin
					or_r[k] <= reg_wdata_in; // RULE_01
				end
			end
		end
	end

	// control bits and sticky flags; a new event beats a write-one clear
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst)
		begin
			ctrl_r <= '0;
		end
		else
		begin
			if (reg_wr_in && reg_addr_in == REG_CTRL)
			begin
				ctrl_r.wpe  <= reg_wdata_in[CT_WPE_BIT];
				ctrl_r.decode_conflict_enable <= reg_wdata_in[CT_DECODE_CONFLICT_ENABLE_BIT];
				ctrl_r.external_master_wait_state <= reg_wdata_in[CT_EXTERNAL_MASTER_WAIT_STATE_BIT];
			end
			ctrl_r.wpf <= wp_evt | (ctrl_r.wpf &
				~(reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[CT_WPF_BIT])); // RULE_05
			ctrl_r.adc <= adc_evt | (ctrl_r.adc &
				~(reg_wr_in && reg_addr_in == REG_CTRL && reg_wdata_in[CT_ADC_BIT])); // RULE_03
		end
	end

	// read data one cycle after the read strobe
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst)
		begin
			reg_rdata_out <= '0;
		end
		else
		begin
			reg_rdata_out <= '0;
			if (reg_rd_in)
			begin
				for (int k = 0; k < NUM_LINES; k++)
				begin
					if (reg_addr_in == REG_BR_BASE + 4'(k))
					begin
						reg_rdata_out <= br_r[k];
					end
					if (reg_addr_in == REG_OR_BASE + 4'(k))
					begin
						reg_rdata_out <= or_r[k];
					end
				end
				if (reg_addr_in == REG_CTRL)
				begin
					reg_rdata_out <= {11'h000, ctrl_r};
				end
			end
		end
	end

	// bus cycle sequencer
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst)
		begin
			st_r                <= ST_IDLE;
			cnt_r               <= CNT_ZERO;
			select_line_n_out   <= '1;
			transfer_ack_n_out  <= 1'b1;
			transfer_ack_oe_out <= 1'b0;
			bus_error_n_out     <= 1'b1;
			periph_wait_out     <= 1'b0;
		end
		else if (!as_act)
		begin
			st_r                <= ST_IDLE; // RULE_25
			cnt_r               <= CNT_ZERO;
			select_line_n_out   <= '1;
			transfer_ack_n_out  <= 1'b1;
			transfer_ack_oe_out <= 1'b0;
			bus_error_n_out     <= 1'b1;
			periph_wait_out     <= 1'b0;
		end
		else
		begin
			periph_wait_out <= 1'b0;
			unique case (st_r)
				ST_IDLE:
				begin
					st_r <= ST_HOLD;
					periph_wait_out <= int_space_in & sync2_r.ext & ctrl_r.external_master_wait_state; // RULE_23
					if (decide && win_ok)
					begin
						select_line_n_out <= ~win; // RULE_02 RULE_04
					end
					if ((wp_evt && ctrl_r.wpe) || (adc_evt && ctrl_r.decode_conflict_enable))
					begin
						bus_error_n_out <= 1'b0; // RULE_03 RULE_05
					end
					if (ack_go)
					begin
						transfer_ack_oe_out <= 1'b1;
						if (cnt_init == CNT_ZERO)
						begin
							transfer_ack_n_out <= 1'b0; // RULE_20
						end
						else
						begin
							cnt_r <= cnt_init;
							st_r  <= ST_WAIT;
						end
					end
				end
				ST_WAIT:
				begin
					cnt_r <= cnt_r - 3'h1; // RULE_19
					if (cnt_r == 3'h1)
					begin
						transfer_ack_n_out <= 1'b0;
						st_r <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					st_r <= ST_HOLD;
				end
				default:
				begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst);

	sequence ws2_start_s;
		ack_go && cnt_init == 3'h2;
	endsequence

	sequence ack_late_s;
		transfer_ack_n_out && $past(transfer_ack_n_out) ##1 !transfer_ack_n_out;
	endsequence

	one_select_a: assert property ($onehot0(~select_line_n_out)) // RULE_04
		else $error("more than one select line low");

	iack_nosel_a: assert property (as_act && iack |=> &select_line_n_out) // RULE_08
		else $error("select asserted in acknowledge cycle");

	int_nosel_a: assert property ((st_r == ST_IDLE) && as_act && int_space_in // RULE_07
		|=> &select_line_n_out)
		else $error("select asserted for on-chip access");

	wp_flag_a: assert property (wp_evt |=> ctrl_r.wpf && &select_line_n_out // RULE_05
		&& (bus_error_n_out == !$past(ctrl_r.wpe)))
		else $error("write protect handling wrong");

	cfg_noflag_a: assert property ((st_r == ST_IDLE) && as_act && cfg_access_in // RULE_24
		&& !ctrl_r.adc && !reg_wr_in |=> !ctrl_r.adc)
		else $error("conflict flagged on configuration access");

	release_all_a: assert property (!as_act |=> &select_line_n_out && transfer_ack_n_out // RULE_25
		&& bus_error_n_out && !transfer_ack_oe_out)
		else $error("outputs held after strobe negation");

	zero_ws_a: assert property (ack_go && cnt_init == 3'h0 |=> !transfer_ack_n_out) // RULE_20
		else $error("zero wait ack late");

	two_ws_a: assert property (ws2_start_s ##1 as_act [*2] |-> ack_late_s) // RULE_17
		else $error("two wait state count wrong");

	ext_ack_a: assert property (decide && win_ok && win_code == ACK_EXTERNAL // RULE_18
		|=> !transfer_ack_oe_out && transfer_ack_n_out)
		else $error("ack driven for external region");

	flag_set_a: assert property (adc_evt |=> ctrl_r.adc) // RULE_03
		else $error("conflict flag not set");

endmodule

// ==== verification/ext_mem_model.sv ====
`timescale 1ns/1ps
module ext_mem_model
(
	input  wire logic       clk_sys_in,
	input  wire logic [3:0] select_line_n_in,
	input  wire logic       dev_ack_oe_in,
	input  wire logic [3:0] ack_delay_in,
	output logic            ack_n_out,
	output logic            ack_oe_out
);
	logic [3:0] wait_r = 4'h0;
	logic       sel;
	logic       oe_r = 1'b0;

	assign sel = ~&select_line_n_in;
	assign ack_oe_out = oe_r;
	assign ack_n_out = ~oe_r;

	// cycles spent selected, so the answer can be prompt or slow
	always_ff @(posedge clk_sys_in)
	begin
		wait_r <= sel ? wait_r + 4'h1 : 4'h0;
	end

	// answers only while the unit leaves the ack line undriven
	always_ff @(posedge clk_sys_in)
	begin
		oe_r <= sel && !dev_ack_oe_in && wait_r >= ack_delay_in;
	end
endmodule

// ==== verification/chip_select_wait_state_unit_tb.sv ====
`timescale 1ns/1ps
module chip_select_wait_state_unit_tb
	import cs_pkg::*;
;
	logic              clk_sys_in, rst_in, halt_in, reg_wr_in, reg_rd_in;
	logic              as_n, rd_in, ext_in, ints_in, cfg_in;
	logic              ack_n, ack_oe, bus_error_n, pw, mem_n, mem_oe, ack_line;
	logic [3:0]        reg_addr_in, sel_n, dly;
	logic [15:0]       wdata, rdata;
	logic [2:0]        space;
	logic [ADDR_W-1:0] addr;
	int                errors, n_checks, pw_cnt;

	chip_select_wait_state_unit #(.NUM_LINES(4)) u_chip_select_wait_state_unit (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .halt_in(halt_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(wdata), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .address_strobe_n_in(as_n),
		.read_in(rd_in), .space_in(space), .addr_hi_in(addr), .ext_master_in(ext_in),
		.int_space_in(ints_in), .cfg_access_in(cfg_in), .select_line_n_out(sel_n),
		.transfer_ack_n_out(ack_n), .transfer_ack_oe_out(ack_oe),
		.bus_error_n_out(bus_error_n), .periph_wait_out(pw));
	ext_mem_model u_ext_mem_model (.clk_sys_in(clk_sys_in), .select_line_n_in(sel_n),
		.dev_ack_oe_in(ack_oe), .ack_delay_in(dly), .ack_n_out(mem_n), .ack_oe_out(mem_oe));

	// ack line has a pull-up when nobody drives it
	assign ack_line = ack_oe ? ack_n : (mem_oe ? mem_n : 1'b1);

	initial
	begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	task results;
	begin
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
			errors++;
		end
	end
	endtask

	task chk_n(input int got, input int exp);
	begin
		n_checks++;
		if (got != exp)
		begin
			$display("CHECK FAILED %0t cycle %0d expected %0d", $time, got, exp);
			errors++;
		end
	end
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
	begin
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		wdata <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	end
	endtask

	task rd(input logic [3:0] a, input logic [15:0] exp);
	begin
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_sys_in);
		chk(rdata, exp);
	end
	endtask

	// one bus cycle; xa and xb are the cycles to ack and bus error, -1 for none
	task bus(input logic r, input logic [2:0] s, input logic [10:0] a, input logic e,
		input logic i, input logic c, input logic [3:0] xs, input int xa, input int xb);
		int         fs, fa, fb;
		logic [3:0] sv;
	begin
		fs = -1;
		fa = -1;
		fb = -1;
		sv = 4'hF;
		@(posedge clk_sys_in);
		{rd_in, space, addr, ext_in, ints_in, cfg_in} <= {r, s, a, e, i, c};
		as_n <= 1'b0;
		for (int k = 1; k < 15; k++)
		begin
			@(negedge clk_sys_in);
			if (sel_n !== 4'hF && fs < 0)
			begin
				fs = k;
				sv = sel_n;
			end
			if (ack_line === 1'b0 && fa < 0)
				fa = k;
			if (bus_error_n === 1'b0 && fb < 0)
				fb = k;
			if (pw === 1'b1)
				pw_cnt++;
		end
		@(posedge clk_sys_in);
		as_n <= 1'b1;
		repeat (4) @(negedge clk_sys_in);
		chk({12'h000, sv}, {12'h000, xs});
		chk_n(fs, xs == 4'hF ? -1 : 4);
		chk_n(fa, xa);
		chk_n(fb, xb);
		chk({9'h000, sel_n, ack_n, bus_error_n, ack_oe}, 16'h007E);
	end
	endtask

	task sys_reset;
	begin
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		halt_in <= 1'b1;
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		halt_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
	end
	endtask

	initial
	begin
		{rst_in, halt_in, reg_wr_in, reg_rd_in, as_n} = 5'b11001;
		{rd_in, ext_in, ints_in, cfg_in, reg_addr_in, wdata, space, addr} = '0;
		{dly, errors, n_checks, pw_cnt} = '0;
		sys_reset();
		for (int i = 0; i < 4; i++)
			rd(i, i == 0 ? 16'hC001 : 16'hC000);
		for (int i = 4; i < 8; i++)
			rd(i, 16'hDFFD);
		rd(8, 16'h0000);
		rd(9, 16'h0000);
		bus(1, 6, 0, 0, 0, 0, 4'hE, 10, -1);
		bus(0, 6, 0, 0, 0, 0, 4'hE, 10, -1);
		bus(1, 5, 0, 0, 0, 0, 4'hF, -1, -1);
		bus(1, 7, 0, 0, 0, 0, 4'hF, -1, -1);
		bus(1, 6, 0, 0, 1, 0, 4'hF, -1, -1);
		for (int c = 0; c < 7; c++)
		begin
			wr(4, {c[2:0], 13'h1FFD});
			bus(1, 6, 0, 0, 0, 0, 4'hE, 4 + c, -1);
		end
		wr(4, 16'hFFFD);
		dly = 4'h2;
		bus(1, 6, 0, 0, 0, 0, 4'hE, 7, -1);
		wr(4, 16'h1FFD);
		wr(1, 16'hC005);
		wr(5, 16'h3FFF);
		bus(1, 6, 1, 0, 0, 0, 4'hD, 5, -1);
		bus(0, 6, 1, 0, 0, 0, 4'hF, -1, -1);
		rd(8, 16'h0001);
		wr(8, 16'h0005);
		rd(8, 16'h0004);
		bus(0, 6, 1, 0, 0, 0, 4'hF, -1, 4);
		wr(8, 16'h0003);
		wr(2, 16'hC001);
		bus(1, 6, 0, 0, 0, 0, 4'hE, 4, -1);
		rd(8, 16'h0002);
		wr(8, 16'h000A);
		bus(1, 6, 0, 0, 0, 0, 4'hE, 4, 4);
		wr(8, 16'h000A);
		bus(1, 6, 0, 0, 0, 1, 4'hE, 4, -1);
		rd(8, 16'h0008);
		wr(2, 16'hC000);
		wr(8, 16'h0010);
		bus(1, 6, 1, 1, 0, 0, 4'hD, 6, -1);
		pw_cnt = 0;
		bus(1, 5, 0, 1, 1, 0, 4'hF, -1, -1);
		chk_n(pw_cnt, 1);
		wr(8, 16'h0000);
		wr(3, 16'hC00E);
		bus(0, 6, 3, 0, 0, 0, 4'hF, -1, -1);
		wr(3, 16'hC00F);
		wr(7, 16'h1FFE);
		bus(1, 6, 3, 0, 0, 0, 4'hF, -1, -1);
		bus(0, 6, 3, 0, 0, 0, 4'h7, 4, -1);
		wr(7, 16'h1FFA);
		bus(0, 1, 2, 0, 0, 0, 4'h7, 4, -1);
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(3, 16'hC00F);
		sys_reset();
		rd(3, 16'hC000);
		results();
	end

	// the sequence needs about 560 cycles
	initial
	begin
		#1000000;
		errors++;
		results();
	end
endmodule
